//--- common/r16oa_pkg.sv
`default_nettype none
package r16oa_pkg;

	localparam int          REG_COUNT    = 16;
	localparam logic [3:0]  REG_PC       = 4'h0;
	localparam logic [3:0]  REG_SP       = 4'h1;
	localparam logic [3:0]  REG_SR       = 4'h2;
	localparam logic [3:0]  REG_CG       = 4'h3;

	localparam int          SR_C_BIT     = 0;
	localparam int          SR_Z_BIT     = 1;
	localparam int          SR_N_BIT     = 2;
	localparam int          SR_V_BIT     = 8;

	localparam logic [1:0]  AM_REG       = 2'h0;
	localparam logic [1:0]  AM_IDX       = 2'h1;
	localparam logic [1:0]  AM_IND       = 2'h2;
	localparam logic [1:0]  AM_INC       = 2'h3;

	localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
	localparam logic [15:0] RESET_VALUE  = 16'h0000;
	localparam logic [15:0] WORD_STEP    = 16'h0002;
	localparam logic [15:0] BYTE_STEP    = 16'h0001;

	localparam logic [2:0]  FMT_JUMP     = 3'h1;
	localparam logic [5:0]  FMT_SINGLE   = 6'h04;
	localparam logic [3:0]  FMT_DUAL_MIN = 4'h4;

	localparam logic [3:0]  OP_MOV       = 4'h4;
	localparam logic [3:0]  OP_ADD       = 4'h5;
	localparam logic [3:0]  OP_ADDC      = 4'h6;
	localparam logic [3:0]  OP_SUBC      = 4'h7;
	localparam logic [3:0]  OP_SUB       = 4'h8;
	localparam logic [3:0]  OP_CMP       = 4'h9;
	localparam logic [3:0]  OP_DADD      = 4'hA;
	localparam logic [3:0]  OP_BIT       = 4'hB;
	localparam logic [3:0]  OP_BIC       = 4'hC;
	localparam logic [3:0]  OP_BIS       = 4'hD;
	localparam logic [3:0]  OP_XOR       = 4'hE;
	localparam logic [3:0]  OP_AND       = 4'hF;

	localparam logic [2:0]  SOP_RRC      = 3'h0;
	localparam logic [2:0]  SOP_SWPB     = 3'h1;
	localparam logic [2:0]  SOP_RRA      = 3'h2;
	localparam logic [2:0]  SOP_SXT      = 3'h3;
	localparam logic [2:0]  SOP_PUSH     = 3'h4;
	localparam logic [2:0]  SOP_CALL     = 3'h5;
	localparam logic [2:0]  SOP_RETI     = 3'h6;

	localparam logic [2:0]  JC_NE        = 3'h0;
	localparam logic [2:0]  JC_EQ        = 3'h1;
	localparam logic [2:0]  JC_NC        = 3'h2;
	localparam logic [2:0]  JC_C         = 3'h3;
	localparam logic [2:0]  JC_N         = 3'h4;
	localparam logic [2:0]  JC_GE        = 3'h5;
	localparam logic [2:0]  JC_L         = 3'h6;

	typedef struct packed {
		logic v;
		logic n;
		logic z;
		logic c;
	} r16oa_flags_t;

	typedef struct packed {
		logic [3:0] opcode;
		logic [3:0] src;
		logic       ad;
		logic       byte_op;
		logic [1:0] as;
		logic [3:0] dst;
	} r16oa_instr_t;

endpackage : r16oa_pkg
`default_nettype wire

//--- hdl/r16oa_alu.sv
`default_nettype none
module r16oa_alu import r16oa_pkg::*; (
	input  wire logic         single,
	input  wire logic [3:0]   op,
	input  wire logic [2:0]   sop,
	input  wire logic         byte_op,
	input  wire logic [15:0]  src,
	input  wire logic [15:0]  dst,
	input  wire r16oa_flags_t flags_in,
	output r16oa_flags_t      flags_out,
	output logic [15:0]       result,
	output logic              flags_wr,
	output logic              result_wr
);

	function automatic logic msb(input logic [15:0] x, input logic bw);
		msb = bw ? x[7] : x[15];
	endfunction : msb

	function automatic logic is_zero(input logic [15:0] x, input logic bw);
		is_zero = bw ? (x[7:0] == 8'h00) : (x == 16'h0000);
	endfunction : is_zero

	function automatic logic [16:0] add_carry(input logic [15:0] a, input logic [15:0] b,
		input logic cin, input logic bw);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
		add_carry = bw ? {s[8], 8'h00, s[7:0]} : s;
	endfunction : add_carry

	function automatic logic [16:0] bcd_add(input logic [15:0] a, input logic [15:0] b,
		input logic cin, input logic bw);
		logic [4:0]  d;
		logic        c;
		logic        cb;
		logic [15:0] r;
		c = cin;
		cb = 1'b0;
		r = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			d = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
			if (d > 5'h09) begin
				d = d + 5'h06;
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			r[i*4 +: 4] = d[3:0];
			if (i == 1) begin
				cb = c;
			end
		end
		bcd_add = bw ? {cb, 8'h00, r[7:0]} : {c, r};
	endfunction : bcd_add

	logic [16:0] sum;
	logic [15:0] b_op;
	logic        c_in;
	logic        logic_c;

	always_comb begin
		sum = 17'h00000;
		b_op = 16'h0000;
		c_in = 1'b0;
		logic_c = 1'b0;
		result = dst;
		flags_out = flags_in;
		flags_wr = 1'b0;
		result_wr = 1'b0;
		if (!single) begin
			case (op)
				OP_MOV: begin
					result = src;
					result_wr = 1'b1;
				end
				OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP: begin
					b_op = (op == OP_ADD || op == OP_ADDC) ? src : ~src;
					if (op == OP_ADD) begin
						c_in = 1'b0;
					end else if (op == OP_SUB || op == OP_CMP) begin
						c_in = 1'b1;
					end else begin
						c_in = flags_in.c;
					end
					sum = add_carry(dst, b_op, c_in, byte_op);
					result = sum[15:0];
					flags_out.c = sum[16];
					flags_out.v = (msb(dst, byte_op) == msb(b_op, byte_op)) &&
						(msb(sum[15:0], byte_op) != msb(dst, byte_op));
					flags_wr = 1'b1;
					result_wr = (op != OP_CMP);
				end
				OP_DADD: begin
					sum = bcd_add(src, dst, flags_in.c, byte_op);
					result = sum[15:0];
					flags_out.c = sum[16];
					flags_wr = 1'b1;
					result_wr = 1'b1;
				end
				OP_BIT, OP_AND, OP_XOR: begin
					result = (op == OP_XOR) ? (src ^ dst) : (src & dst);
					flags_out.v = (op == OP_XOR) && msb(src, byte_op) && msb(dst, byte_op);
					logic_c = 1'b1;
					flags_wr = 1'b1;
					result_wr = (op != OP_BIT);
				end
				OP_BIC: begin
					result = dst & ~src;
					result_wr = 1'b1;
				end
				OP_BIS: begin
					result = dst | src;
					result_wr = 1'b1;
				end
				default: begin
				end
			endcase
		end else begin
			case (sop)
				SOP_RRC, SOP_RRA: begin
					if (byte_op) begin
						result = {8'h00, (sop == SOP_RRC) ? flags_in.c : src[7], src[7:1]};
					end else begin
						result = {(sop == SOP_RRC) ? flags_in.c : src[15], src[15:1]};
					end
					flags_out.c = src[0];
					flags_out.v = 1'b0;
					flags_wr = 1'b1;
					result_wr = 1'b1;
				end
				SOP_SWPB: begin
					result = {src[7:0], src[15:8]};
					result_wr = 1'b1;
				end
				SOP_SXT: begin
					result = {{8{src[7]}}, src[7:0]};
					flags_out.v = 1'b0;
					logic_c = 1'b1;
					flags_wr = 1'b1;
					result_wr = 1'b1;
				end
				default: begin
					result = src;
				end
			endcase
		end
		if (flags_wr) begin
			flags_out.n = msb(result, byte_op);
			flags_out.z = is_zero(result, byte_op);
			if (logic_c) begin
				flags_out.c = !is_zero(result, byte_op);
			end
		end
	end

endmodule : r16oa_alu
`default_nettype wire

//--- hdl/r16oa_core.sv
`default_nettype none
module r16oa_core import r16oa_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	output logic             bus_req,
	output logic             bus_we,
	output logic             bus_byte,
	output logic [15:0]      bus_addr,
	output logic [15:0]      bus_wdata,
	input  wire logic [15:0] bus_rdata,
	input  wire logic        bus_ack
);

	typedef enum logic [3:0] {
		S_VEC, S_FETCH, S_DECODE, S_SRCX, S_SRCM, S_DSTX,
		S_DSTM, S_EXEC, S_WR, S_POPSR, S_POPPC
	} r16oa_state_t;

	logic         rst_meta_reg;
	logic         rst_sync_n_reg;
	r16oa_state_t state_reg;
	logic [15:0]  rf [REG_COUNT];
	logic [15:0]  ir_reg;
	logic [15:0]  opnd_reg;
	logic [15:0]  src_addr_reg;
	logic [15:0]  dst_q_reg;
	logic [15:0]  dst_addr_reg;
	logic [15:0]  wr_data_reg;
	logic         bus_req_reg;
	logic         bus_we_reg;
	logic         bus_byte_reg;
	logic [15:0]  bus_addr_reg;
	logic [15:0]  bus_wdata_reg;

	r16oa_instr_t ir_f;
	logic [3:0]   src_n;
	logic [2:0]   sop;
	logic         is_jump;
	logic         is_single;
	logic         is_dual;
	logic         bw;
	logic         cg;
	logic         src_imm;
	logic         src_ext;
	logic         src_mem;
	logic         dst_mem;
	logic         dst_to_mem;
	logic         push_call;
	logic         got;
	logic         exec_now;
	logic         jump_now;
	logic [15:0]  pc;
	logic [15:0]  sp;
	logic [15:0]  src_val;
	logic [15:0]  dst_val;
	logic [15:0]  acc_addr;
	logic         acc_byte;
	logic [15:0]  alu_res;
	r16oa_flags_t alu_flags;
	r16oa_flags_t sr_flags;
	logic         alu_flags_wr;
	logic         alu_result_wr;
	r16oa_state_t exec_next;

	// constant generator: R3 in any mode, R2 in the two indirect modes
	function automatic logic [15:0] cg_value(input logic [3:0] n, input logic [1:0] am);
		if (n == REG_CG) begin
			case (am)
				AM_REG:  cg_value = 16'h0000;
				AM_IDX:  cg_value = 16'h0001;
				AM_IND:  cg_value = 16'h0002;
				default: cg_value = 16'hFFFF;
			endcase
		end else begin
			cg_value = (am == AM_IND) ? 16'h0004 : 16'h0008;
		end
	endfunction : cg_value

	// indexed base: R2 gives absolute, R0 gives symbolic relative to the offset word
	function automatic logic [15:0] index_base(input logic [3:0] n, input logic [15:0] v);
		index_base = (n == REG_SR) ? 16'h0000 : v;
	endfunction : index_base

	function automatic logic take_jump(input logic [2:0] cond, input r16oa_flags_t f);
		case (cond)
			JC_NE:   take_jump = !f.z;
			JC_EQ:   take_jump = f.z;
			JC_NC:   take_jump = !f.c;
			JC_C:    take_jump = f.c;
			JC_N:    take_jump = f.n;
			JC_GE:   take_jump = !(f.n ^ f.v);
			JC_L:    take_jump = f.n ^ f.v;
			default: take_jump = 1'b1;
		endcase
	endfunction : take_jump

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	assign ir_f = r16oa_instr_t'(ir_reg);
	assign sop = ir_reg[9:7];
	assign is_jump = (ir_reg[15:13] == FMT_JUMP);
	assign is_single = (ir_reg[15:10] == FMT_SINGLE);
	assign is_dual = (ir_f.opcode >= FMT_DUAL_MIN);
	assign src_n = is_single ? ir_f.dst : ir_f.src;
	assign bw = ir_f.byte_op;
	assign pc = rf[REG_PC];
	assign sp = rf[REG_SP];
	assign sr_flags = '{v: rf[REG_SR][SR_V_BIT], n: rf[REG_SR][SR_N_BIT],
		z: rf[REG_SR][SR_Z_BIT], c: rf[REG_SR][SR_C_BIT]};

	assign cg = (src_n == REG_CG) || (src_n == REG_SR && ir_f.as[1]);
	assign src_imm = (ir_f.as == AM_INC) && (src_n == REG_PC);
	assign src_ext = src_imm || (ir_f.as == AM_IDX && !cg);
	assign src_mem = !cg && !src_imm && (ir_f.as != AM_REG);
	assign dst_mem = is_dual && ir_f.ad;
	assign dst_to_mem = dst_mem || (is_single && src_mem);
	assign push_call = is_single && (sop == SOP_PUSH || sop == SOP_CALL);

	// register operands are read straight from the file, so reg-reg work needs no extra state
	assign src_val = cg ? cg_value(src_n, ir_f.as) : ((src_ext || src_mem) ? opnd_reg : rf[src_n]);
	assign dst_val = dst_mem ? dst_q_reg : rf[ir_f.dst];

	assign got = bus_req_reg && bus_ack;
	assign jump_now = (state_reg == S_DECODE) && is_jump;
	assign exec_now = (state_reg == S_EXEC) || ((state_reg == S_DECODE) && !is_jump &&
		(is_single || is_dual) && !src_ext && !src_mem && !dst_mem);

	r16oa_alu u_alu (
		.single    (is_single),
		.op        (ir_f.opcode),
		.sop       (sop),
		.byte_op   (bw),
		.src       (src_val),
		.dst       (dst_val),
		.flags_in  (sr_flags),
		.flags_out (alu_flags),
		.result    (alu_res),
		.flags_wr  (alu_flags_wr),
		.result_wr (alu_result_wr)
	);

	always_comb begin
		if (push_call) begin
			exec_next = S_WR;
		end else if (is_single && sop == SOP_RETI) begin
			exec_next = S_POPSR;
		end else if (alu_result_wr && dst_to_mem) begin
			exec_next = S_WR;
		end else begin
			exec_next = S_FETCH;
		end
	end

	always_comb begin
		case (state_reg)
			S_VEC:          acc_addr = RESET_VECTOR;
			S_SRCM:         acc_addr = src_addr_reg;
			S_DSTM, S_WR:   acc_addr = dst_addr_reg;
			S_POPSR, S_POPPC: acc_addr = sp;
			default:        acc_addr = pc;
		endcase
		acc_byte = bw && (state_reg == S_SRCM || state_reg == S_DSTM || state_reg == S_WR) &&
			!(is_single && sop == SOP_CALL);
	end

	// one request per access state; it is held until acknowledged
	always_ff @(posedge clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			bus_req_reg <= 1'b0;
			bus_we_reg <= 1'b0;
			bus_byte_reg <= 1'b0;
			bus_addr_reg <= RESET_VALUE;
			bus_wdata_reg <= RESET_VALUE;
		end else if (got) begin
			bus_req_reg <= 1'b0;
			bus_we_reg <= 1'b0;
		end else if (!bus_req_reg && state_reg != S_DECODE && state_reg != S_EXEC) begin
			bus_req_reg <= 1'b1;
			bus_we_reg <= (state_reg == S_WR);
			bus_byte_reg <= acc_byte;
			bus_addr_reg <= acc_addr;
			bus_wdata_reg <= wr_data_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			state_reg <= S_VEC;
			ir_reg <= RESET_VALUE;
			opnd_reg <= RESET_VALUE;
			src_addr_reg <= RESET_VALUE;
			dst_q_reg <= RESET_VALUE;
			dst_addr_reg <= RESET_VALUE;
			wr_data_reg <= RESET_VALUE;
		end else begin
			case (state_reg)
				S_VEC: begin
					if (got) begin
						state_reg <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (got) begin
						ir_reg <= bus_rdata;
						state_reg <= S_DECODE;
					end
				end
				S_DECODE: begin
					if (is_jump || !(is_single || is_dual)) begin
						state_reg <= S_FETCH;
					end else if (src_ext) begin
						state_reg <= S_SRCX;
					end else if (src_mem) begin
						src_addr_reg <= rf[src_n];
						state_reg <= S_SRCM;
					end else if (dst_mem) begin
						state_reg <= S_DSTX;
					end else begin
						state_reg <= exec_next;
					end
				end
				S_SRCX: begin
					if (got && src_imm) begin
						opnd_reg <= bus_rdata;
						state_reg <= dst_mem ? S_DSTX : S_EXEC;
					end else if (got) begin
						src_addr_reg <= bus_rdata + index_base(src_n, rf[src_n]);
						state_reg <= S_SRCM;
					end
				end
				S_SRCM: begin
					if (got) begin
						opnd_reg <= bw ? {8'h00, bus_rdata[7:0]} : bus_rdata;
						dst_addr_reg <= src_addr_reg;
						state_reg <= dst_mem ? S_DSTX : S_EXEC;
					end
				end
				S_DSTX: begin
					if (got) begin
						dst_addr_reg <= bus_rdata + index_base(ir_f.dst, rf[ir_f.dst]);
						state_reg <= S_DSTM;
					end
				end
				S_DSTM: begin
					if (got) begin
						dst_q_reg <= bw ? {8'h00, bus_rdata[7:0]} : bus_rdata;
						state_reg <= S_EXEC;
					end
				end
				S_EXEC: begin
					state_reg <= exec_next;
				end
				S_WR, S_POPPC: begin
					if (got) begin
						state_reg <= S_FETCH;
					end
				end
				S_POPSR: begin
					if (got) begin
						state_reg <= S_POPPC;
					end
				end
				default: begin
					state_reg <= S_FETCH;
				end
			endcase
			if (exec_now) begin
				if (push_call) begin
					dst_addr_reg <= sp - WORD_STEP;
					wr_data_reg <= (sop == SOP_CALL) ? pc : src_val;
				end else begin
					wr_data_reg <= alu_res;
				end
			end
		end
	end

	// all register writes sit here; later assignments win, so results override flags
	always_ff @(posedge clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				rf[i] <= RESET_VALUE;
			end
		end else begin
			case (state_reg)
				S_VEC: begin
					if (got) begin
						rf[REG_PC] <= bus_rdata;
					end
				end
				S_FETCH, S_SRCX, S_DSTX: begin
					if (got) begin
						rf[REG_PC] <= pc + WORD_STEP;
					end
				end
				S_SRCM: begin
					if (got && ir_f.as == AM_INC) begin
						// stack and program counter stay word aligned even for byte access
						rf[src_n] <= rf[src_n] + ((bw && src_n > REG_SP) ? BYTE_STEP : WORD_STEP);
					end
				end
				S_POPSR: begin
					if (got) begin
						rf[REG_SR] <= bus_rdata;
						rf[REG_SP] <= sp + WORD_STEP;
					end
				end
				S_POPPC: begin
					if (got) begin
						rf[REG_PC] <= bus_rdata;
						rf[REG_SP] <= sp + WORD_STEP;
					end
				end
				default: begin
				end
			endcase
			if (jump_now && take_jump(ir_reg[12:10], sr_flags)) begin
				rf[REG_PC] <= pc + {{5{ir_reg[9]}}, ir_reg[9:0], 1'b0};
			end
			if (exec_now) begin
				if (alu_flags_wr) begin
					rf[REG_SR][SR_C_BIT] <= alu_flags.c;
					rf[REG_SR][SR_Z_BIT] <= alu_flags.z;
					rf[REG_SR][SR_N_BIT] <= alu_flags.n;
					rf[REG_SR][SR_V_BIT] <= alu_flags.v;
				end
				if (push_call) begin
					rf[REG_SP] <= sp - WORD_STEP;
					if (sop == SOP_CALL) begin
						rf[REG_PC] <= src_val;
					end
				end else if (alu_result_wr && !dst_to_mem) begin
					// a move into R0 is the computed_jump
					rf[ir_f.dst] <= bw ? {8'h00, alu_res[7:0]} : alu_res;
				end
			end
		end
	end

	assign bus_req = bus_req_reg;
	assign bus_we = bus_we_reg;
	assign bus_byte = bus_byte_reg;
	assign bus_addr = bus_addr_reg;
	assign bus_wdata = bus_wdata_reg;

endmodule : r16oa_core
`default_nettype wire

//--- testbench/r16oa_core_asserts.sv
`default_nettype none
module r16oa_core_asserts import r16oa_pkg::*; (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        bus_req,
	input wire logic        bus_we,
	input wire logic        bus_byte,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	input wire logic        bus_ack
);
	logic        seen_reg;
	logic [15:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] jump_tgt;
	logic        rd_done;

	assign rd_done  = bus_req && bus_ack && !bus_we;
	assign jump_tgt = addr_reg + WORD_STEP + {{5{data_reg[9]}}, data_reg[9:0], 1'b0};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seen_reg <= 1'b0;
		end else if (bus_req) begin
			seen_reg <= 1'b1;
		end
	end

	// last completed read, so the next access can be tied to it
	always_ff @(posedge clk) begin
		if (rd_done) begin
			addr_reg <= bus_addr;
			data_reg <= bus_rdata;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// decode takes its own cycle and the next request is registered one cycle after it
	sequence s_exec_gap;
		!bus_req ##1 !bus_req ##1 bus_req;
	endsequence

	sequence s_fetch_at(logic [15:0] a);
		!bus_req ##[1:4] (bus_req && !bus_we && bus_addr == a);
	endsequence

	a_req_holds: assert property (
		bus_req && !bus_ack |=> bus_req && $stable({bus_we, bus_byte, bus_addr}))
		else $error("request changed before acknowledge");
	a_wdata_holds: assert property (
		bus_req && bus_we && !bus_ack |=> $stable(bus_wdata))
		else $error("write data changed before acknowledge");
	a_req_drops: assert property (
		bus_req && bus_ack |=> !bus_req)
		else $error("request kept after acknowledge");
	a_vector_first: assert property (
		bus_req && !seen_reg |-> !bus_we && bus_addr == RESET_VECTOR)
		else $error("first access is not the vector read");
	a_regop_single: assert property (
		rd_done && bus_rdata[15:12] >= OP_MOV && bus_rdata[11:10] != 2'h0 && !bus_rdata[7]
		&& bus_rdata[5:4] == AM_REG && bus_rdata[3:2] != 2'h0
		|=> s_exec_gap ##0 bus_addr == addr_reg + WORD_STEP)
		else $error("register operation took more than one cycle");
	a_call_push: assert property (
		rd_done && bus_rdata[15:7] == 9'h025 && bus_rdata[5:4] == AM_REG
		|=> s_exec_gap ##0 (bus_we && !bus_byte && !bus_addr[0]
		&& bus_wdata == addr_reg + WORD_STEP))
		else $error("call did not push the return address");
	a_jump_target: assert property (
		rd_done && bus_rdata[15:13] == FMT_JUMP
		|=> s_fetch_at(addr_reg + WORD_STEP) or s_fetch_at(jump_tgt))
		else $error("jump continued at a wrong address");
	a_imm_step: assert property (
		rd_done && bus_rdata[15:12] >= OP_MOV && bus_rdata[11:8] == REG_PC
		&& bus_rdata[5:4] == AM_INC
		|=> s_fetch_at(addr_reg + WORD_STEP))
		else $error("immediate word not read at next address");
endmodule : r16oa_core_asserts

bind r16oa_core r16oa_core_asserts u_chk (
	.clk      (clk),
	.reset_n  (reset_n),
	.bus_req  (bus_req),
	.bus_we   (bus_we),
	.bus_byte (bus_byte),
	.bus_addr (bus_addr),
	.bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata),
	.bus_ack  (bus_ack)
);
`default_nettype wire

//--- testbench/r16oa_mem_model.sv
`default_nettype none
module r16oa_mem_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        bus_req,
	input  wire logic        bus_we,
	input  wire logic        bus_byte,
	input  wire logic [15:0] bus_addr,
	input  wire logic [15:0] bus_wdata,
	input  var  int          dly,
	output logic [15:0]      bus_rdata,
	output logic             bus_ack,
	output logic             done
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  mem [0:65535];
	logic [15:0] lo_addr;
	logic [15:0] hi_addr;
	int          wait_cnt;

	assign lo_addr = bus_byte ? bus_addr : {bus_addr[15:1], 1'b0};
	assign hi_addr = {bus_addr[15:1], 1'b1};

	initial begin
		bus_rdata = 16'h0000;
		bus_ack   = 1'b0;
		wait_cnt  = 0;
	end

	// data lines toggle outside the answer so a late sample reads garbage
	always @(negedge clk) begin
		if (bus_req && !bus_ack && wait_cnt > dly) begin
			bus_ack   <= 1'b1;
			bus_rdata <= bus_byte ? {8'h00, mem[lo_addr]} : {mem[hi_addr], mem[lo_addr]};
		end else begin
			bus_ack   <= 1'b0;
			bus_rdata <= ~bus_rdata;
		end
		wait_cnt <= (bus_req && !bus_ack) ? wait_cnt + 1 : 0;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			done <= 1'b0;
		end else if (bus_req && bus_ack && bus_we) begin
			mem[lo_addr] <= bus_wdata[7:0];
			if (!bus_byte) begin
				mem[hi_addr] <= bus_wdata[15:8];
			end
			if (bus_addr == 16'h01FE) begin
				done <= 1'b1;
			end
		end
	end
endmodule : r16oa_mem_model
`default_nettype wire

//--- testbench/risc16_operand_addressing_bench.sv
`default_nettype none
module risc16_operand_addressing_bench import r16oa_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        reset_n;
	logic        bus_req;
	logic        bus_we;
	logic        bus_byte;
	logic [15:0] bus_addr;
	logic [15:0] bus_wdata;
	logic [15:0] bus_rdata;
	logic        bus_ack;
	logic        done;
	int          mem_dly;
	int          err_total;
	int          n_tests;

	r16oa_core uut (
		.clk      (clk),
		.reset_n  (reset_n),
		.bus_req  (bus_req),
		.bus_we   (bus_we),
		.bus_byte (bus_byte),
		.bus_addr (bus_addr),
		.bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata),
		.bus_ack  (bus_ack)
	);

	r16oa_mem_model far (
		.clk      (clk),
		.reset_n  (reset_n),
		.bus_req  (bus_req),
		.bus_we   (bus_we),
		.bus_byte (bus_byte),
		.bus_addr (bus_addr),
		.bus_wdata(bus_wdata),
		.dly      (mem_dly),
		.bus_rdata(bus_rdata),
		.bus_ack  (bus_ack),
		.done     (done)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	task automatic put(input logic [15:0] a, input logic [15:0] w);
		far.mem[a]         = w[7:0];
		far.mem[a + 16'h1] = w[15:8];
	endtask : put

	function automatic logic [15:0] rd(input logic [15:0] a);
		return {far.mem[a + 16'h1], far.mem[a]};
	endfunction : rd

	task automatic load(input logic [15:0] w [$]);
		put(RESET_VECTOR, 16'hC000);
		foreach (w[i]) begin
			put(16'hC000 + 16'(2 * i), w[i]);
		end
	endtask : load

	// every program ends by storing to 01FE, which the memory reports as done
	task automatic run(input int d);
		int k;
		mem_dly = d;
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		k = 0;
		while (bus_req !== 1'b1 && k < 50) begin
			@(negedge clk);
			k++;
		end
		check("first address", bus_addr, RESET_VECTOR);
		if (k == 50) begin
			test_done();
		end
		k = 0;
		while (done !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (done !== 1'b1) begin
			err_total++;
			$display("MISMATCH program end expected done seen timeout");
			test_done();
		end
	endtask : run

	task automatic t_regops();
		put(16'h0204, 16'h00EE);
		load('{16'h4034, 16'h1234, 16'h4035, 16'h00F0, 16'h5405, 16'h4036, 16'h80FF,
			16'h5446, 16'h4582, 16'h0200, 16'h4682, 16'h0202, 16'h44C2, 16'h0205,
			16'h4482, 16'h01FE, 16'h3FFF});
		run(0);
		check("word sum", rd(16'h0200), 16'h1324);
		check("byte sum", rd(16'h0202), 16'h0033);
		check("byte store", rd(16'h0204), 16'h34EE);
		$display("test regops end");
	endtask : t_regops

	task automatic t_modes();
		put(16'h0300, 16'hA5A5);
		put(16'h0302, 16'h5A5A);
		put(16'h0304, 16'h1111);
		load('{16'h4036, 16'h0300, 16'h4627, 16'h4782, 16'h0204, 16'h4682, 16'h0206,
			16'h4638, 16'h4682, 16'h0208, 16'h4696, 16'h0002, 16'h0006,
			16'h4482, 16'h01FE, 16'h3FFF});
		run(3);
		check("indirect read", rd(16'h0204), 16'hA5A5);
		check("indirect base", rd(16'h0206), 16'h0300);
		check("autoinc base", rd(16'h0208), 16'h0302);
		check("indexed move", rd(16'h0308), 16'h1111);
		$display("test modes end");
	endtask : t_modes

	task automatic t_flow(input int d);
		// target kept clear of words that read like an immediate move when fetched as data
		put(16'h0310, 16'hC040);
		put(16'hC040, 16'h4182);
		put(16'hC042, 16'h01FE);
		put(16'hC044, 16'h3FFF);
		put(16'h01FE, 16'h0000);
		put(16'h020A, 16'h0000);
		put(16'h020C, 16'h0000);
		put(16'h020E, 16'h0000);
		load('{16'h4031, 16'h0400, 16'h4038, 16'hC020, 16'h1288, 16'h9404, 16'h2001,
			16'h531A, 16'h932A, 16'h2001, 16'h531A, 16'h4A82, 16'h020E, 16'h4620,
			16'h3FFF, 16'h3FFF, 16'h4182, 16'h020A, 16'h41A2, 16'h020C, 16'h4036,
			16'h0310, 16'h4130, 16'h3FFF});
		run(d);
		check("stack after call", rd(16'h020A), 16'h03FE);
		check("pushed return", rd(16'h020C), 16'hC00A);
		check("not equal count", rd(16'h020E), 16'h0001);
		check("indirect branch", rd(16'h01FE), 16'h0400);
		$display("test flow end");
	endtask : t_flow

	task automatic t_ops();
		load('{16'h4031, 16'h0400, 16'h4034, 16'h00F0, 16'h4035, 16'h0F0F, 16'hE405,
			16'h1185, 16'hC405, 16'h1084, 16'h1104, 16'h1204, 16'h4582, 16'h0210,
			16'h4482, 16'h0212, 16'h4482, 16'h01FE, 16'h3FFF});
		run(2);
		check("xor sxt bic", rd(16'h0210), 16'hFF0F);
		check("swpb rra", rd(16'h0212), 16'hF800);
		check("pushed word", rd(16'h03FE), 16'hF800);
		$display("test ops end");
	endtask : t_ops

	initial begin
		reset_n   = 1'b0;
		mem_dly   = 0;
		err_total = 0;
		n_tests   = 0;
		t_regops();
		t_modes();
		t_flow(1);
		t_flow(5);
		t_ops();
		test_done();
	end
endmodule : risc16_operand_addressing_bench
`default_nettype wire
